// *** logic/sirq_consts.vh ***
// register offsets, field positions and reset values of the serial port control block
`ifndef SIRQ_CONSTS_VH
`define SIRQ_CONSTS_VH
`define SIRQ_ADDR_CTRL     2'h0
`define SIRQ_ADDR_STAT     2'h1
`define SIRQ_ADDR_DATA     2'h2
`define SIRQ_ADDR_BREAK    2'h3
`define SIRQ_CTRL_RXIE     0
`define SIRQ_CTRL_MASTER   1
`define SIRQ_CTRL_PEN      2
`define SIRQ_CTRL_TXIE     3
`define SIRQ_CTRL_RESET    8'h0_2
`define SIRQ_STAT_ERROR_IRQ_ENABLE    0
`define SIRQ_STAT_MFDE     1
`define SIRQ_STAT_MODE_FAULT_FLAG     2
`define SIRQ_STAT_TXE      3
`define SIRQ_STAT_OVRN     4
`define SIRQ_STAT_RXF      5
`define SIRQ_STAT_RESET    8'h0_0
`define SIRQ_BRK_BCE       0
`define SIRQ_DIV_HALF      4'h4
`endif

// *** logic/sirq_ctrl.v ***
// byte-wide serial port: flags, interrupt gating, transmit queue, resets, break control
// What this block does
// RULE1 - transmit request is empty flag and transmit enable
// RULE2 - receive-full request needs receive enable and port enable
// RULE3 - one error enable gates both overrun and mode fault
// RULE4 - mode fault never sets while mode fault detect enable is low
// RULE5 - receive-full sets on every byte moved into receive data
// RULE6 - receive-full and error flags share one receive/error request
// RULE7 - empty flag sets whenever a byte moves into the shift register
// RULE8 - data register write clears empty flag and queues the byte
// RULE9 - master starts a queued byte right after the previous one, no gap
// RULE10 - software writes data only while empty flag is high
// RULE11 - status read with receive-full set, then data read, clears it
// RULE12 - slave resends last shift register contents if nothing queued
// RULE13 - port disabled: empty set, transfer aborted, shifter and count cleared
// RULE14 - only system reset resets control bits (master select to 1, rest to 0) and sticky flags
// RULE15 - master mode fault with detection clears the port enable
// RULE16 - wait mode keeps running; enabled requests wake the processor
// RULE17 - stop halts keeping registers; reset while stopped resets fully
// RULE18 - break with clear enable low freezes flags; two-step finishes after
// RULE19 - break with clear enable high: cleared flags stay cleared
// RULE20 - break with clear enable low: data writes have no effect
// RULE21 - overrun sets at bit-1 capture while receive data unread; old kept
// RULE22 - mode fault clears by status read then control write, no fault present
// RULE23 - master with detection sets mode fault while slave select is low
// RULE24 - interrupt requests are levels held while flag and enables hold
// RULE25 - flags change on bus clock; set wins over simultaneous clear
`include "sirq_consts.vh"
module sirq_ctrl #(
    parameter DIV_HALF = `SIRQ_DIV_HALF
) (
    // clock and reset
    input  wire       clk_i,
    input  wire       rstn_i,
    // register port
    input  wire [1:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    // system state
    input  wire       stop_i,
    input  wire       break_i,
    // serial pins
    input  wire       sck_i,
    output wire       sck_o,
    output wire       sck_oe_o,
    input  wire       mosi_i,
    output wire       mosi_o,
    output wire       mosi_oe_o,
    input  wire       miso_i,
    output wire       miso_o,
    output wire       miso_oe_o,
    input  wire       ssn_i,
    // interrupt requests
    output wire       tx_irq_o,
    output wire       rx_err_irq_o,
    output wire       wake_o
);
    reg        rst_s1_r, rst_s2_r;
    wire       rstn = rst_s2_r;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // pin synchronisers; first stage read only by second
    reg [2:0] sck_s_r, ss_s_r, mosi_s_r, miso_s_r;
    always @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            sck_s_r  <= 3'h0;
            ss_s_r   <= 3'h7;
            mosi_s_r <= 3'h0;
            miso_s_r <= 3'h0;
        end else begin
            sck_s_r  <= {sck_s_r[1:0], sck_i};
            ss_s_r   <= {ss_s_r[1:0], ssn_i};
            mosi_s_r <= {mosi_s_r[1:0], mosi_i};
            miso_s_r <= {miso_s_r[1:0], miso_i};
        end
    end
    wire sck_rise = sck_s_r[1] & ~sck_s_r[2];
    wire sck_fall = ~sck_s_r[1] & sck_s_r[2];
    wire ss_low   = ~ss_s_r[1];
    wire ss_fall  = ~ss_s_r[1] & ss_s_r[2];

    // control bits
    reg       rx_irq_enable_r, master_select_r, port_enable_r, tx_irq_enable_r;
    reg       error_irq_enable_r, mode_fault_detect_enable_r, break_clear_enable_r;
    // flags
    reg       tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, mode_fault_flag_r;
    reg       rxf_armed_r, mode_fault_flag_armed_r, ovr_lost_r;
    // data path
    reg [7:0] tx_data_r, rx_data_r, shift_r;
    reg [3:0] bit_cnt_r;
    reg       busy_r, sck_r;
    reg [3:0] div_r;
    reg       mosi_r, miso_r;

    wire run      = port_enable_r & ~stop_i;                         // RULE16 RULE17
    wire freeze   = break_i & ~break_clear_enable_r;                 // RULE18 RULE19
    wire st_rd    = rd_i & (addr_i == `SIRQ_ADDR_STAT);
    wire dat_rd   = rd_i & (addr_i == `SIRQ_ADDR_DATA);
    wire dat_wr   = wr_i & (addr_i == `SIRQ_ADDR_DATA) & ~freeze;    // RULE20
    wire ctl_wr   = wr_i & (addr_i == `SIRQ_ADDR_CTRL);
    wire mode_fault_flag_cond = master_select_r & mode_fault_detect_enable_r & ss_low & port_enable_r;
    wire mode_fault_flag_set = mode_fault_flag_cond;                                       // RULE4 RULE23
    wire slave_sel = ~master_select_r & ss_low;

    // master clock divider: half period counts
    wire div_tick = (div_r == DIV_HALF[3:0] - 4'h1);
    wire m_edge   = busy_r & master_select_r & div_tick;
    wire cap      = master_select_r ? (m_edge & ~sck_r) : (slave_sel & sck_rise);
    wire shf      = master_select_r ? (m_edge & sck_r) : (slave_sel & sck_fall);
    wire rx_in    = master_select_r ? miso_s_r[1] : mosi_s_r[1];
    wire done     = shf & (bit_cnt_r == 4'h7);
    wire bit1_cap = cap & (bit_cnt_r == 4'h0);
    wire ovr_set  = bit1_cap & rx_full_flag_r;                       // RULE21
    wire rxf_set  = done & ~overrun_flag_r & ~ovr_set & ~ovr_lost_r; // RULE5
    wire load_m   = master_select_r & ~tx_empty_flag_r & (~busy_r | done); // RULE9
    wire load_s   = ~master_select_r & ~tx_empty_flag_r & ss_fall & ~busy_r;
    wire load     = run & (load_m | load_s);                         // RULE7

    always @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin                                             // RULE14 RULE17
            rx_irq_enable_r            <= 1'b0;
            master_select_r            <= 1'b1;
            port_enable_r              <= 1'b0;
            tx_irq_enable_r            <= 1'b0;
            error_irq_enable_r         <= 1'b0;
            mode_fault_detect_enable_r <= 1'b0;
            break_clear_enable_r       <= 1'b0;
            rx_full_flag_r             <= 1'b0;
            overrun_flag_r             <= 1'b0;
            mode_fault_flag_r          <= 1'b0;
            rxf_armed_r                <= 1'b0;
            mode_fault_flag_armed_r               <= 1'b0;
            ovr_lost_r                 <= 1'b0;
            rx_data_r                  <= 8'h00;
            tx_data_r                  <= 8'h00;
        end else begin
            if (ctl_wr) begin
                rx_irq_enable_r <= wdata_i[`SIRQ_CTRL_RXIE];
                master_select_r <= wdata_i[`SIRQ_CTRL_MASTER];
                port_enable_r   <= wdata_i[`SIRQ_CTRL_PEN];
                tx_irq_enable_r <= wdata_i[`SIRQ_CTRL_TXIE];
            end
            if (wr_i && addr_i == `SIRQ_ADDR_STAT) begin
                error_irq_enable_r         <= wdata_i[`SIRQ_STAT_ERROR_IRQ_ENABLE];
                mode_fault_detect_enable_r <= wdata_i[`SIRQ_STAT_MFDE];
            end
            if (wr_i && addr_i == `SIRQ_ADDR_BREAK)
                break_clear_enable_r <= wdata_i[`SIRQ_BRK_BCE];
            if (dat_wr)
                tx_data_r <= wdata_i;
            if (rxf_set)
                rx_data_r <= shift_r;                                 // RULE21
            // two-step arms; frozen in break so first step survives
            if (st_rd && !freeze) begin
                rxf_armed_r  <= rx_full_flag_r;
                mode_fault_flag_armed_r <= mode_fault_flag_r;
            end
            if (rxf_set | ovr_set)
                rx_full_flag_r <= 1'b1;                               // RULE25
            else if (dat_rd && rxf_armed_r && !freeze) begin          // RULE11
                rx_full_flag_r <= 1'b0;
                rxf_armed_r    <= 1'b0;
            end
            if (ovr_set)
                overrun_flag_r <= 1'b1;
            else if (dat_rd && !freeze && !rx_full_flag_r)
                overrun_flag_r <= 1'b0;
            // byte caught in overrun stays lost even if the flag is cleared mid-byte
            if (ovr_set)
                ovr_lost_r <= 1'b1;                                   // RULE21
            else if (done || !port_enable_r)
                ovr_lost_r <= 1'b0;
            if (mode_fault_flag_set) begin
                mode_fault_flag_r <= 1'b1;                           // RULE25
                port_enable_r     <= 1'b0;                            // RULE15
            end else if (ctl_wr && mode_fault_flag_armed_r && !freeze) begin     // RULE22
                mode_fault_flag_r <= 1'b0;
                mode_fault_flag_armed_r      <= 1'b0;
            end
        end
    end

    // transfer engine; partial reset while disabled
    always @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            tx_empty_flag_r <= 1'b1;
            shift_r         <= 8'h00;
            bit_cnt_r       <= 4'h0;
            busy_r          <= 1'b0;
            sck_r           <= 1'b0;
            div_r           <= 4'h0;
            mosi_r          <= 1'b0;
            miso_r          <= 1'b0;
        end else if (!port_enable_r) begin                            // RULE13
            tx_empty_flag_r <= 1'b1;
            shift_r         <= 8'h00;
            bit_cnt_r       <= 4'h0;
            busy_r          <= 1'b0;
            sck_r           <= 1'b0;
            div_r           <= 4'h0;
        end else if (!stop_i) begin
            if (load)
                tx_empty_flag_r <= 1'b1;                             // RULE7 RULE25
            else if (dat_wr)
                tx_empty_flag_r <= 1'b0;                             // RULE8 RULE10
            if (busy_r && master_select_r)
                div_r <= div_tick ? 4'h0 : div_r + 4'h1;
            if (m_edge)
                sck_r <= ~sck_r;
            if (load) begin
                shift_r   <= tx_data_r;
                bit_cnt_r <= 4'h0;
                busy_r    <= 1'b1;
                div_r     <= 4'h0;
                mosi_r    <= tx_data_r[7];
                miso_r    <= tx_data_r[7];
            end else begin
                if (~master_select_r && ss_fall && !busy_r) begin     // RULE12
                    busy_r <= 1'b1;
                    miso_r <= shift_r[7];
                end
                if (cap)
                    shift_r <= {shift_r[6:0], rx_in};
                if (shf) begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    mosi_r    <= shift_r[7];
                    miso_r    <= shift_r[7];
                end
                if (done) begin
                    busy_r    <= 1'b0;
                    bit_cnt_r <= 4'h0;
                end
                if (~master_select_r && !ss_low) begin
                    busy_r    <= 1'b0;
                    bit_cnt_r <= 4'h0;
                end
            end
        end
    end

    // pin drive; released to general purpose when disabled
    assign sck_o     = sck_r;
    assign sck_oe_o  = port_enable_r & master_select_r;
    assign mosi_o    = mosi_r;
    assign mosi_oe_o = port_enable_r & master_select_r;
    assign miso_o    = miso_r;
    assign miso_oe_o = port_enable_r & slave_sel;

    // level requests
    assign tx_irq_o     = tx_empty_flag_r & tx_irq_enable_r;                       // RULE1 RULE24
    assign rx_err_irq_o = (rx_full_flag_r & rx_irq_enable_r & port_enable_r)     // RULE2 RULE6
                        | (error_irq_enable_r & (overrun_flag_r | mode_fault_flag_r)); // RULE3
    assign wake_o       = tx_irq_o | rx_err_irq_o;                                // RULE16

    always @(posedge clk_i or negedge rstn) begin
        if (!rstn)
            rdata_o <= 8'h00;
        else if (rd_i) begin
            case (addr_i)
            `SIRQ_ADDR_CTRL:  rdata_o <= {4'h0, tx_irq_enable_r, port_enable_r,
                                          master_select_r, rx_irq_enable_r};
            `SIRQ_ADDR_STAT:  rdata_o <= {2'h0, rx_full_flag_r, overrun_flag_r,
                                          tx_empty_flag_r, mode_fault_flag_r,
                                          mode_fault_detect_enable_r, error_irq_enable_r};
            `SIRQ_ADDR_DATA:  rdata_o <= rx_data_r;
            default:          rdata_o <= {7'h00, break_clear_enable_r};
            endcase
        end else
            rdata_o <= 8'h00;
    end
endmodule // sirq_ctrl

// *** verification/sirq_slave_model.sv ***
// far-side serial slave device answering the port in master mode
module sirq_slave_model (
    input  wire logic sck_i,
    input  wire logic mosi_i,
    input  wire logic ssn_i,
    output wire logic miso_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx_q [3] = '{8'h3C, 8'hC3, 8'h5A};
    logic [7:0] got_q [$];
    logic [7:0] sh = 8'h3C;
    logic [7:0] rx = 8'h00;
    logic       last = 1'b0;
    int         nb = 0;
    // deselected: line released, so show the inverse of the last bit
    assign miso_o = ssn_i ? ~last : sh[7];
    always @(posedge ssn_i) last <= sh[7];
    // deselected slave ignores the clock, so the settling edge at reset is no shift
    always @(posedge sck_i) begin
        if (!ssn_i) begin
            rx <= {rx[6:0], mosi_i};
            nb <= nb + 1;
        end
    end
    always @(negedge sck_i) begin
        if (!ssn_i && nb == 8) begin
            got_q.push_back(rx);
            sh <= tx_q[got_q.size() % 3];
            nb <= 0;
        end else if (!ssn_i) begin
            sh <= {sh[6:0], 1'b0};
        end
    end
endmodule // sirq_slave_model

// *** verification/sirq_ctrl_sva.sv ***
// checker of the serial port control block, seen from its ports
`include "sirq_consts.vh"
module sirq_ctrl_sva (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       break_i,
    input wire logic       ssn_i,
    input wire logic       sck_oe_o,
    input wire logic       mosi_oe_o,
    input wire logic       miso_oe_o,
    input wire logic       tx_irq_o,
    input wire logic       rx_err_irq_o,
    input wire logic       wake_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic txie_s, rxie_s, error_irq_enable_s, mfde_s, bce_s;
    wire  wc = wr_i && addr_i == `SIRQ_ADDR_CTRL;
    wire  wd = wr_i && addr_i == `SIRQ_ADDR_DATA;
    // enable shadows; only a system reset clears them
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {txie_s, rxie_s, error_irq_enable_s, mfde_s, bce_s} <= 5'h00;
        end else begin
            if (wc) {txie_s, rxie_s} <= {wdata_i[3], wdata_i[0]};
            if (wr_i && addr_i == `SIRQ_ADDR_STAT) {mfde_s, error_irq_enable_s} <= wdata_i[1:0];
            if (wr_i && addr_i == `SIRQ_ADDR_BREAK) bce_s <= wdata_i[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_fault; $fell(ssn_i) && mosi_oe_o && mfde_s; endsequence
    sequence s_nodet; $fell(ssn_i) && mosi_oe_o && !mfde_s; endsequence
    property p_tx_off; !txie_s |-> !tx_irq_o; endproperty
    property p_tx_idle; wc && wdata_i[3] && !wdata_i[2] |-> ##[1:2] tx_irq_o; endproperty
    property p_rx_off; !rxie_s && !error_irq_enable_s |-> !rx_err_irq_o; endproperty
    property p_mf_off; s_fault |-> ##[1:8] !mosi_oe_o; endproperty
    property p_mf_irq; s_fault and error_irq_enable_s |-> ##[1:8] rx_err_irq_o; endproperty
    property p_no_mf; s_nodet |=> mosi_oe_o [*8]; endproperty
    property p_wake; wake_o == (tx_irq_o || rx_err_irq_o); endproperty
    property p_brk_wr; break_i && !bce_s && wd && tx_irq_o |=> tx_irq_o; endproperty
    property p_dis_oe; wc && !wdata_i[2] |=> !sck_oe_o && !mosi_oe_o && !miso_oe_o; endproperty
    property p_level; tx_irq_o && !wr_i |=> tx_irq_o; endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx request without enable");
    a_tx_idle: assert property (p_tx_idle) else $error("tx request missing");
    a_rx_off: assert property (p_rx_off) else $error("rx request without enable");
    a_mf_off: assert property (p_mf_off) else $error("port kept after fault");
    a_mf_irq: assert property (p_mf_irq) else $error("fault request missing");
    a_no_mf: assert property (p_no_mf) else $error("fault with detect off");
    a_wake: assert property (p_wake) else $error("wake not request or");
    a_brk_wr: assert property (p_brk_wr) else $error("data write in break acted");
    a_dis_oe: assert property (p_dis_oe) else $error("pins driven while off");
    a_level: assert property (p_level) else $error("tx request dropped");
endmodule // sirq_ctrl_sva
bind sirq_ctrl sirq_ctrl_sva chk_u (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .break_i,
    .ssn_i, .sck_oe_o, .mosi_oe_o, .miso_oe_o, .tx_irq_o, .rx_err_irq_o, .wake_o);

// *** verification/sirq_ctrl_tb.sv ***
// self-checking bench of the serial port control block
`include "sirq_consts.vh"
module sirq_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [1:0] wa; logic [7:0] wd; logic [1:0] ra; logic [7:0] ex, mk;
        logic ti;} sirq_row_t;
    logic       clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, break_i = 1'b0;
    logic       ssn_i = 1'b1, stop_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00, rv;
    wire  [7:0] rdata_o;
    wire        sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, sm_miso;
    wire        tx_irq_o, rx_err_irq_o, wake_o;
    int         miscompares = 0, n_tests = 0;
    sirq_row_t  rows [4] = '{
        '{`SIRQ_ADDR_CTRL, 8'h08, `SIRQ_ADDR_STAT, 8'h08, 8'h08, 1'b1},
        '{`SIRQ_ADDR_CTRL, 8'h01, `SIRQ_ADDR_CTRL, 8'h01, 8'h0F, 1'b0},
        '{`SIRQ_ADDR_STAT, 8'h03, `SIRQ_ADDR_STAT, 8'h0B, 8'h3F, 1'b0},
        '{`SIRQ_ADDR_BREAK, 8'h01, `SIRQ_ADDR_BREAK, 8'h01, 8'h01, 1'b0}};
    logic [7:0] sent [3] = '{8'h96, 8'h69, 8'h0F};
    always #25 clk_i = ~clk_i;
    sirq_ctrl dut_u (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .stop_i, .break_i, .sck_i(sck_oe_o ? sck_o : 1'b0), .sck_o, .sck_oe_o,
        .mosi_i(mosi_oe_o ? mosi_o : ~mosi_o), .mosi_o, .mosi_oe_o,
        .miso_i(miso_oe_o ? miso_o : sm_miso), .miso_o, .miso_oe_o, .ssn_i,
        .tx_irq_o, .rx_err_irq_o, .wake_o);
    sirq_slave_model model_u (.sck_i(sck_o), .mosi_i(mosi_o), .ssn_i, .miso_o(sm_miso));
    task automatic chk(string nm, logic [7:0] got, logic [7:0] ex);
        n_tests++;
        if (got !== ex) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge clk_i) begin addr_i <= a; wdata_i <= d; wr_i <= 1'b1; end
        @(posedge clk_i) wr_i <= 1'b0;
    endtask
    task automatic rd(logic [1:0] a);
        @(posedge clk_i) begin addr_i <= a; rd_i <= 1'b1; end
        @(posedge clk_i) rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task automatic poll(int b);
        rv = 8'h00;
        for (int k = 0; k < 300 && rv[b] !== 1'b1; k++) rd(`SIRQ_ADDR_STAT);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #2_000_000;
        miscompares++;
        test_done;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(`SIRQ_ADDR_CTRL); chk("ctrl reset", rv, 8'h02);
        rd(`SIRQ_ADDR_STAT); chk("stat reset", rv, 8'h08);
        foreach (rows[r]) begin
            wr(rows[r].wa, rows[r].wd);
            rd(rows[r].ra);
            chk("row read", rv & rows[r].mk, rows[r].ex);
            chk("row tx req", tx_irq_o, rows[r].ti);
        end
        wr(`SIRQ_ADDR_STAT, 8'h00);
        wr(`SIRQ_ADDR_BREAK, 8'h00);
        wr(`SIRQ_ADDR_CTRL, 8'h06);
        ssn_i <= 1'b0;
        wr(`SIRQ_ADDR_DATA, sent[0]);
        poll(`SIRQ_STAT_TXE);
        wr(`SIRQ_ADDR_DATA, sent[1]);
        rd(`SIRQ_ADDR_STAT); chk("queued", rv & 8'h08, 8'h00);
        poll(`SIRQ_STAT_RXF);
        rd(`SIRQ_ADDR_DATA); chk("rx byte", rv, 8'h3C);
        rd(`SIRQ_ADDR_STAT); chk("rx clr", rv & 8'h28, 8'h08);
        wr(`SIRQ_ADDR_DATA, sent[2]);
        poll(`SIRQ_STAT_OVRN);
        rd(`SIRQ_ADDR_DATA); chk("old kept", rv, 8'hC3);
        rd(`SIRQ_ADDR_DATA);
        for (int k = 0; k < 300 && model_u.got_q.size() < 3; k++) @(posedge clk_i);
        foreach (sent[j]) chk("wire byte", model_u.got_q[j], sent[j]);
        ssn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wr(`SIRQ_ADDR_STAT, 8'h03);
        ssn_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("fault off", mosi_oe_o, 1'b0);
        chk("fault req", rx_err_irq_o, 1'b1);
        rd(`SIRQ_ADDR_STAT); chk("fault flag", rv & 8'h34, 8'h04);
        @(posedge clk_i) ssn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wr(`SIRQ_ADDR_CTRL, 8'h02);
        rd(`SIRQ_ADDR_STAT); chk("fault clr", rv & 8'h3F, 8'h0B);
        wr(`SIRQ_ADDR_CTRL, 8'h0E);
        wr(`SIRQ_ADDR_STAT, 8'h00);
        ssn_i <= 1'b0;
        wr(`SIRQ_ADDR_DATA, 8'h5A);
        stop_i <= 1'b1;
        repeat (80) @(posedge clk_i);
        rd(`SIRQ_ADDR_STAT); chk("stop hold", rv & 8'h08, 8'h00);
        chk("stop wire", 8'(model_u.got_q.size()), 8'h03);
        @(posedge clk_i) stop_i <= 1'b0;
        for (int k = 0; k < 300 && model_u.got_q.size() < 4; k++) @(posedge clk_i);
        chk("resume byte", model_u.got_q[3], 8'h5A);
        break_i <= 1'b1;
        wr(`SIRQ_ADDR_DATA, 8'hAA);
        rd(`SIRQ_ADDR_STAT); chk("break write", rv & 8'h08, 8'h08);
        @(posedge clk_i) break_i <= 1'b0;
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(`SIRQ_ADDR_STAT); chk("stat again", rv, 8'h08);
        test_done;
    end
endmodule // sirq_ctrl_tb
